// file: crl_pkg.sv
// constants shared by the control register loader
package crl_pkg;
  // ----------------------------------------
  // host port addresses
  // ----------------------------------------
  localparam logic [2:0] ADDR_HOLD0 = 3'h0;
  localparam logic [2:0] ADDR_HOLD1 = 3'h1;
  localparam logic [2:0] ADDR_HOLD2 = 3'h2;
  localparam logic [2:0] ADDR_HOLD3 = 3'h3;
  localparam logic [2:0] ADDR_DEST  = 3'h4;
  // ----------------------------------------
  // destination codes
  // ----------------------------------------
  localparam logic [3:0] DEST_CARRIER_CF   = 4'h0;
  localparam logic [3:0] DEST_RESAMPLER_CF = 4'h1;
  localparam logic [3:0] DEST_INPUT_THRESH = 4'h2;
  localparam logic [3:0] DEST_LAST_CTRL    = 4'h8;
  localparam logic [3:0] DEST_SNAPSHOT     = 4'h9;
  localparam int         NUM_CTRL_REGS     = 9;
  // ----------------------------------------
  // timing and field layout
  // ----------------------------------------
  localparam logic [2:0] XFER_DELAY_CLKS   = 3'h4;
  localparam int         THRESH_MSB        = 7;
  localparam logic [7:0] THRESH_USABLE_MAX = 8'hB5;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
endpackage

// file: crl_sync.sv
// two-flop synchroniser for host strobes
`timescale 1ns/10ps
`default_nettype none
module crl_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_reg;
  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  // first stage feeds only the second stage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: crl_loader.sv
// control register loader: host byte port, holding bytes, control bank, gain snapshot
//
// Functional notes
// RULE1 - nine 32-bit control registers, host-loaded only
// RULE2 - host writes holding bytes before address
// RULE3 - copy to destination on fourth clock
// RULE4 - host waits four clocks before new holding
// RULE5 - host may skip unused holding bytes
// RULE6 - load strobe high copies holding to carrier
// RULE7 - every sampled-high edge makes a transfer
// RULE8 - strobe no sooner than two clocks after write
// RULE9 - next load allowed one clock after strobe
// RULE10 - destination nine snapshots accumulator upper byte
// RULE11 - read low six clocks later drives byte
// RULE12 - exponent bits 7-5, fraction bits 4-0
// RULE13 - host strobes asynchronous to device clock
// RULE14 - destination 0 carrier center frequency word
// RULE15 - destination 1 resampler center frequency word
// RULE16 - destination 2 threshold in bits 7-0
// RULE17 - threshold above 1.4142 never reports exceedance
// RULE18 - addresses 0-3 holding bytes, 4 destination
// RULE19 - 3-bit address, 8-bit data, write rising edge
// RULE20 - data bus released unless read; write synchronised
`timescale 1ns/10ps
`default_nettype none
module crl_loader #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 3
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  input  wire logic              WR_N,
  input  wire logic              RD_N,
  input  wire logic [ADDR_W-1:0] HOST_ADDRESS_BUS,
  input  wire logic [DATA_W-1:0] HOST_DATA_BUS_IN,
  output var  logic [DATA_W-1:0] HOST_DATA_BUS_OUT,
  output var  logic              HOST_DATA_BUS_OE,
  input  wire logic              CENTER_FREQ_LOAD_STROBE,
  input  wire logic [7:0]        GAIN_ACCUM_UPPER,
  input  wire logic [7:0]        INPUT_MAGNITUDE,
  output var  logic [31:0]       CARRIER_CENTER_FREQUENCY,
  output var  logic [31:0]       RESAMPLER_CENTER_FREQUENCY,
  output var  logic [31:0]       INPUT_LEVEL_THRESHOLD,
  output var  logic [31:0]       CTRL_REG3,
  output var  logic [31:0]       CTRL_REG4,
  output var  logic [31:0]       CTRL_REG5,
  output var  logic [31:0]       CTRL_REG6,
  output var  logic [31:0]       CTRL_REG7,
  output var  logic [31:0]       CTRL_REG8,
  output var  logic              INPUT_LEVEL_EXCEEDED,
  output var  logic              LOAD_BUSY
);
  typedef enum logic [1:0] {CRL_IDLE, CRL_COUNT, CRL_COPY} crl_state_t;

  // ----------------------------------------
  // host write capture
  // ----------------------------------------
  // address and data registered every clock and used as sampled when the synchronised strobe rises; the host keeps
  // them stable until the synchronised edge is seen (asynchronous strobe)
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic              wr_sync;
  logic              wr_prev_reg;
  logic              rd_sync;
  wire logic         wr_rise = wr_sync & ~wr_prev_reg; // RULE19 RULE13

  crl_sync #(.RESET_VAL(1'b1)) u_wr_sync (
    .CLK_SYS  (CLK_SYS),
    .RST_N    (RST_N),
    .async_in (WR_N),
    .sync_out (wr_sync)
  ); // RULE20 RULE13

  crl_sync #(.RESET_VAL(1'b1)) u_rd_sync (
    .CLK_SYS  (CLK_SYS),
    .RST_N    (RST_N),
    .async_in (RD_N),
    .sync_out (rd_sync)
  ); // RULE13

  // edge detector looks only at the second stage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wr_prev_reg <= 1'b1;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_prev_reg <= wr_sync;
      wr_addr_reg <= HOST_ADDRESS_BUS;
      wr_data_reg <= HOST_DATA_BUS_IN;
    end
  end

  // ----------------------------------------
  // holding bytes and destination address
  // ----------------------------------------
  logic [31:0] hold_reg;
  logic [3:0]  dest_reg;
  wire logic   wr_hold0 = wr_rise && (wr_addr_reg == crl_pkg::ADDR_HOLD0); // RULE18
  wire logic   wr_hold1 = wr_rise && (wr_addr_reg == crl_pkg::ADDR_HOLD1);
  wire logic   wr_hold2 = wr_rise && (wr_addr_reg == crl_pkg::ADDR_HOLD2);
  wire logic   wr_hold3 = wr_rise && (wr_addr_reg == crl_pkg::ADDR_HOLD3);
  wire logic   wr_dest  = wr_rise && (wr_addr_reg == crl_pkg::ADDR_DEST);  // RULE18

  // skipped bytes simply keep their old value
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      hold_reg <= crl_pkg::CTRL_RESET;
      dest_reg <= '0;
    end else begin
      if (wr_hold0) hold_reg[7:0]   <= wr_data_reg[7:0]; // RULE5
      if (wr_hold1) hold_reg[15:8]  <= wr_data_reg[7:0];
      if (wr_hold2) hold_reg[23:16] <= wr_data_reg[7:0];
      if (wr_hold3) hold_reg[31:24] <= wr_data_reg[7:0];
      if (wr_dest)  dest_reg        <= wr_data_reg[3:0]; // RULE18
    end
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  crl_state_t  state_reg;
  crl_state_t  state_next;
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  wire logic   cnt_done = (cnt_reg == crl_pkg::XFER_DELAY_CLKS - 3'h1);

  // a later address write during the count does not restart it but changes the destination; host must not do so (wait rule)
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      CRL_IDLE: begin
        cnt_next = 3'h1;
        if (wr_dest) state_next = CRL_COUNT; // RULE2
      end
      CRL_COUNT: begin
        cnt_next = cnt_reg + 3'h1;
        if (cnt_done) state_next = CRL_COPY; // RULE3 RULE4
      end
      CRL_COPY: begin
        cnt_next   = 3'h1;
        state_next = wr_dest ? CRL_COUNT : CRL_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_reg <= CRL_IDLE;
      cnt_reg   <= 3'h1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  wire logic copy_go = (state_reg == CRL_COPY); // RULE3

  // ----------------------------------------
  // control register bank
  // ----------------------------------------
  logic [31:0] ctrl_reg [crl_pkg::NUM_CTRL_REGS];
  logic [7:0]  snap_reg;
  wire logic   cf_strobe = CENTER_FREQ_LOAD_STROBE; // RULE6 RULE7

  function automatic logic sel(input logic [3:0] d, input logic [3:0] idx);
    sel = (d == idx);
  endfunction

  // strobe load and address load both write from the same holding bytes
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      for (int i = 0; i < crl_pkg::NUM_CTRL_REGS; i++) begin
        ctrl_reg[i] <= crl_pkg::CTRL_RESET;
      end
      snap_reg <= '0;
    end else begin
      for (int i = 0; i < crl_pkg::NUM_CTRL_REGS; i++) begin
        if (copy_go && sel(dest_reg, 4'(i))) ctrl_reg[i] <= hold_reg; // RULE1 RULE14 RULE15
      end
      if (cf_strobe) ctrl_reg[crl_pkg::DEST_CARRIER_CF] <= hold_reg; // RULE6 RULE7 RULE9
      if (copy_go && sel(dest_reg, crl_pkg::DEST_SNAPSHOT)) snap_reg <= GAIN_ACCUM_UPPER; // RULE10 RULE12
    end
  end

  // ----------------------------------------
  // outputs, read-back and level detector
  // ----------------------------------------
  wire logic [7:0] thresh    = ctrl_reg[crl_pkg::DEST_INPUT_THRESH][crl_pkg::THRESH_MSB:0]; // RULE16
  wire logic       exceed_nx = (thresh <= crl_pkg::THRESH_USABLE_MAX) && (INPUT_MAGNITUDE > thresh); // RULE17
  wire logic       read_on   = ~rd_sync; // RULE11 RULE20

  // all outputs registered; data bus driven only while the synchronised read is low
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      HOST_DATA_BUS_OUT          <= '0;
      HOST_DATA_BUS_OE           <= 1'b0;
      CARRIER_CENTER_FREQUENCY   <= crl_pkg::CTRL_RESET;
      RESAMPLER_CENTER_FREQUENCY <= crl_pkg::CTRL_RESET;
      INPUT_LEVEL_THRESHOLD      <= crl_pkg::CTRL_RESET;
      CTRL_REG3                  <= crl_pkg::CTRL_RESET;
      CTRL_REG4                  <= crl_pkg::CTRL_RESET;
      CTRL_REG5                  <= crl_pkg::CTRL_RESET;
      CTRL_REG6                  <= crl_pkg::CTRL_RESET;
      CTRL_REG7                  <= crl_pkg::CTRL_RESET;
      CTRL_REG8                  <= crl_pkg::CTRL_RESET;
      INPUT_LEVEL_EXCEEDED       <= 1'b0;
      LOAD_BUSY                  <= 1'b0;
    end else begin
      HOST_DATA_BUS_OUT          <= DATA_W'(snap_reg); // RULE12
      HOST_DATA_BUS_OE           <= read_on;           // RULE11 RULE20
      CARRIER_CENTER_FREQUENCY   <= ctrl_reg[0];       // RULE14
      RESAMPLER_CENTER_FREQUENCY <= ctrl_reg[1];       // RULE15
      INPUT_LEVEL_THRESHOLD      <= {24'h000000, thresh}; // RULE16
      CTRL_REG3                  <= ctrl_reg[3];
      CTRL_REG4                  <= ctrl_reg[4];
      CTRL_REG5                  <= ctrl_reg[5];
      CTRL_REG6                  <= ctrl_reg[6];
      CTRL_REG7                  <= ctrl_reg[7];
      CTRL_REG8                  <= ctrl_reg[crl_pkg::DEST_LAST_CTRL];
      INPUT_LEVEL_EXCEEDED       <= exceed_nx;         // RULE17
      LOAD_BUSY                  <= (state_next != CRL_IDLE);
    end
  end
endmodule
`default_nettype wire

// file: crl_loader_chk.sv
// assertion checker on the loader ports
`timescale 1ns/10ps
`default_nettype none
module crl_loader_chk (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        WR_N,
  input wire logic        RD_N,
  input wire logic [2:0]  HOST_ADDRESS_BUS,
  input wire logic [7:0]  HOST_DATA_BUS_IN,
  input wire logic        HOST_DATA_BUS_OE,
  input wire logic        CENTER_FREQ_LOAD_STROBE,
  input wire logic [7:0]  INPUT_MAGNITUDE,
  input wire logic [31:0] CARRIER_CENTER_FREQUENCY,
  input wire logic [31:0] INPUT_LEVEL_THRESHOLD,
  input wire logic        INPUT_LEVEL_EXCEEDED,
  input wire logic        LOAD_BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire logic [7:0] thr = INPUT_LEVEL_THRESHOLD[7:0];
  // busy for exactly the four-clock copy, then idle
  sequence copy_span;
    LOAD_BUSY [*4] ##1 !LOAD_BUSY;
  endsequence
  chk_copy_four: assert property ($rose(LOAD_BUSY) |-> copy_span)
    else $error("copy span wrong");
  chk_dest_starts: assert property ($rose(WR_N) && HOST_ADDRESS_BUS == 3'h4
    && HOST_DATA_BUS_IN[3:0] < 4'h9 && !LOAD_BUSY |-> ##[1:6] $rose(LOAD_BUSY)) else $error("no copy");
  // an address copy reaches the output one clock after busy has dropped
  chk_cf_source: assert property ($changed(CARRIER_CENTER_FREQUENCY)
    |-> $past(CENTER_FREQ_LOAD_STROBE, 2) || ($past(LOAD_BUSY, 2) && !$past(LOAD_BUSY)))
    else $error("carrier changed");
  chk_thresh_resv: assert property (INPUT_LEVEL_THRESHOLD[31:8] == 24'h0)
    else $error("reserved bits set");
  // flag and threshold output come from the same stored byte, so they line up;
  // the flag saw the magnitude one clock earlier, and reset forces it low
  chk_high_thresh: assert property (thr > 8'hB5 |-> !INPUT_LEVEL_EXCEEDED)
    else $error("exceed above cutoff");
  chk_exceed_set: assert property ($past(RST_N) && thr <= 8'hB5 && $past(INPUT_MAGNITUDE) > thr
    |-> INPUT_LEVEL_EXCEEDED) else $error("exceed missed");
  chk_read_drive: assert property (!RD_N [*5] |-> HOST_DATA_BUS_OE)
    else $error("bus not driven");
  chk_bus_release: assert property (RD_N [*5] |-> !HOST_DATA_BUS_OE)
    else $error("bus driven idle");
endmodule
bind crl_loader crl_loader_chk u_crl_loader_chk (.*);
`default_nettype wire

// file: crl_host.sv
// microprocessor model on the host byte port
`timescale 1ns/10ps
`default_nettype none
module crl_host (
  input  wire logic       CLK_SYS,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  output var  logic       wr_n,
  output var  logic       rd_n,
  output var  logic [2:0] addr,
  output var  logic [7:0] data
);
  // --------------------
  // host cycles
  // --------------------
  initial begin
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 3'h7;
    data = 8'h00;
  end
  // byte write; held long past the edge since the port latches after sync
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    #1 addr = a;
    data = d;
    wr_n = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1 wr_n = 1'b1;
    repeat (8) @(posedge CLK_SYS);
    #1 data = ~d; // complement driven after the hold, so the lines show no stale byte
  endtask
  // read no sooner than six clocks after the snapshot write
  task automatic rd(output logic [7:0] q);
    repeat (6) @(posedge CLK_SYS);
    #1 rd_n = 1'b0;
    repeat (5) @(posedge CLK_SYS);
    q = bus_oe ? bus_out : 8'hZZ;
    #1 rd_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// file: control_register_loader_bench.sv
// self-checking bench for the control register loader
`timescale 1ns/10ps
`default_nettype none
module control_register_loader_bench;
  typedef struct packed {logic [3:0] dest; logic [31:0] word; logic [31:0] exp;} crl_row_t;
  logic        clk_sys, rst_n, wr_n, rd_n, strobe, oe, exceeded, busy;
  logic [2:0]  addr;
  logic [7:0]  din, dout, gain, mag, q;
  wire  logic [31:0] bank [0:8];
  int          n_mismatch = 0;
  int          tests_run = 0;
  crl_row_t    rows [9] = '{'{4'h0, 32'h87654321, 32'h87654321}, '{4'h1, 32'h00000001, 32'h00000001},
    '{4'h2, 32'hFFFFFF80, 32'h80}, '{4'h3, 32'hA5A5A5A5, 32'hA5A5A5A5}, '{4'h4, 32'h000007FF, 32'h7FF},
    '{4'h5, 32'h12345678, 32'h12345678}, '{4'h6, 32'hFFFFFFFF, 32'hFFFFFFFF},
    '{4'h7, 32'h80000000, 32'h80000000}, '{4'h8, 32'h0F0F0F0F, 32'h0F0F0F0F}};
  crl_loader u_crl_loader (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .WR_N(wr_n), .RD_N(rd_n),
    .HOST_ADDRESS_BUS(addr), .HOST_DATA_BUS_IN(din), .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe),
    .CENTER_FREQ_LOAD_STROBE(strobe), .GAIN_ACCUM_UPPER(gain), .INPUT_MAGNITUDE(mag),
    .CARRIER_CENTER_FREQUENCY(bank[0]), .RESAMPLER_CENTER_FREQUENCY(bank[1]), .INPUT_LEVEL_THRESHOLD(bank[2]),
    .CTRL_REG3(bank[3]), .CTRL_REG4(bank[4]), .CTRL_REG5(bank[5]), .CTRL_REG6(bank[6]),
    .CTRL_REG7(bank[7]), .CTRL_REG8(bank[8]), .INPUT_LEVEL_EXCEEDED(exceeded), .LOAD_BUSY(busy));
  crl_host u_crl_host (.CLK_SYS(clk_sys), .bus_out(dout), .bus_oe(oe), .wr_n(wr_n), .rd_n(rd_n),
    .addr(addr), .data(din));
  // --------------------
  // helpers
  // --------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // all four holding bytes, low byte first
  task automatic hold(input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      u_crl_host.wr(3'(i), w[8*i +: 8]);
  endtask
  // single low byte then destination; the other holding bytes are skipped
  task automatic short_load(input logic [7:0] b, input logic [7:0] d);
    u_crl_host.wr(3'h0, b);
    u_crl_host.wr(3'h4, d);
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict;
  end
  // --------------------
  // main sequence
  // --------------------
  initial begin
    rst_n = 1'b0;
    strobe = 1'b0;
    gain = {3'h5, 5'h05};
    mag = 8'hFF;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check("carrier reset", 32'h0, bank[0]);
    check("oe reset", 32'h0, {31'h0, oe});
    foreach (rows[i]) begin
      hold(rows[i].word);
      u_crl_host.wr(3'h4, {4'h0, rows[i].dest});
      repeat (4) @(posedge clk_sys);
      check("control word", rows[i].exp, bank[rows[i].dest]);
      check("busy idle", 32'h0, {31'h0, busy});
    end
    hold(32'hCAFE0042);
    @(posedge clk_sys);
    #1 strobe = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 strobe = 1'b0;
    repeat (3) @(posedge clk_sys);
    check("strobe load", 32'hCAFE0042, bank[0]);
    u_crl_host.wr(3'h0, 8'h5A);
    @(posedge clk_sys);
    #1 strobe = 1'b1;
    @(posedge clk_sys);
    #1 strobe = 1'b0;
    repeat (3) @(posedge clk_sys);
    check("strobe reload", 32'hCAFE005A, bank[0]);
    short_load(8'hC0, 8'h02);
    check("threshold", 32'hC0, bank[2]);
    check("no exceed", 32'h0, {31'h0, exceeded});
    short_load(8'h40, 8'h02);
    check("exceed", 32'h1, {31'h0, exceeded});
    short_load(8'h99, 8'h0A);
    check("refused code", 32'hCAFE005A, bank[0]);
    u_crl_host.wr(3'h4, 8'h09);
    gain = 8'h3C;
    u_crl_host.rd(q);
    check("snapshot byte", {24'h0, 3'h5, 5'h05}, {24'h0, q});
    repeat (4) @(posedge clk_sys);
    check("bus released", 32'h0, {31'h0, oe});
    // reset again in mid-run: registered outputs must clear
    #1 rst_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check("carrier cleared", 32'h0, bank[0]);
    check("exceed cleared", 32'h0, {31'h0, exceeded});
    print_verdict;
  end
endmodule
`default_nettype wire
